// ### rtl/arsa_pkg.sv
/*
 * Shared constants and carriers for the access-list route and swap action block.
 * Assumes the register bus is AHB-Lite with 32-bit data and word-aligned registers.
 */
package arsa_pkg;

    // Widths of frame and action fields.
    localparam int MODE_W = 4;
    localparam int MAC_W = 48;
    localparam int IP_W = 128;
    localparam int KEY_W = 96;
    localparam int DOM_W = 2;
    localparam int POL_W = 10;
    localparam int PT_W = 6;
    localparam int HOP_W = 8;
    localparam int OFS_W = 6;
    localparam int SIP_DEPTH_DEF = 4;

    // Register byte offsets.
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] DEFACT_OFS = 12'h004;
    localparam logic [11:0] DEFMLO_OFS = 12'h008;
    localparam logic [11:0] DEFMHI_OFS = 12'h00c;
    localparam logic [11:0] SWAPC_OFS = 12'h010;
    localparam logic [11:0] HIT0_OFS = 12'h014;
    localparam logic [11:0] HIT1_OFS = 12'h018;
    localparam logic [11:0] STAT_OFS = 12'h01c;
    localparam logic [11:0] SIP_OFS = 12'h040;

    // Field positions inside the registers.
    localparam int CTRL_EN0 = 0;
    localparam int CTRL_EN1 = 1;
    localparam int CTRL_SEL0 = 2;
    localparam int CTRL_SEL1 = 3;
    localparam int DA_MODE_LSB = 0;
    localparam int DA_DOM_LSB = 4;
    localparam int DA_HOP = 6;
    localparam int DA_SEQ = 7;
    localparam int SC_HOP_LSB = 0;
    localparam int SC_OFS_LSB = 8;

    // Reset values.
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DEFACT_RST = 32'h0000_0000;
    localparam logic [31:0] DEFMAC_RST = 32'h0000_0000;
    localparam logic [31:0] SWAPC_RST = 32'h0000_0040;

    // Address and mode field positions.
    localparam int MAC_MC_BIT = 40;
    localparam logic [3:0] IP4_MC = 4'he;
    localparam logic [7:0] IP6_MC = 8'hff;
    localparam int RS_UC = 0;
    localparam int RS_MC = 1;
    localparam int RS_OVL = 2;
    localparam int RS_SWAP = 3;
    localparam logic [MODE_W-1:0] MODE_DMAC_REPL = 4'h8;
    localparam int AM_PT_EN = 0;
    localparam int AM_PT_LSB = 1;
    localparam int AM_POL_EN = 16;
    localparam int AM_POL_LSB = 17;

    typedef enum logic [2:0] {
        SUB_DMAC = 3'b000,
        SUB_SMAC = 3'b001,
        SUB_MSWAP = 3'b010,
        SUB_MSWAP_UC = 3'b011,
        SUB_BSWAP = 3'b100,
        SUB_BSWAP_UC = 3'b101,
        SUB_ISWAP = 3'b110,
        SUB_SMAC_ISWAP = 3'b111
    } arsa_sub_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LK0 = 2'b01,
        ST_LK1 = 2'b10,
        ST_OUT = 2'b11
    } arsa_state_t;

    typedef struct packed {
        logic [MODE_W-1:0] mode;
        logic [MAC_W-1:0] mac;
        logic [DOM_W-1:0] dom;
        logic hop;
        logic seq;
    } arsa_action_t;

    typedef struct packed {
        logic [MAC_W-1:0] dmac;
        logic [MAC_W-1:0] smac;
        logic [IP_W-1:0] dip;
        logic [IP_W-1:0] sip;
        logic ipv6;
        logic sam_seq;
        logic [POL_W-1:0] pol;
    } arsa_frame_t;

    typedef struct packed {
        logic uc_route;
        logic mc_route;
        logic pt_en;
        logic [PT_W-1:0] pt_idx;
        logic pol_en;
        logic [POL_W-1:0] pol_idx;
        logic [DOM_W-1:0] dom;
        logic hop_preset;
        logic hop_dec;
        logic [HOP_W-1:0] hop_val;
    } arsa_ctl_t;

endpackage

// ### rtl/arsa_rewrite.sv
/*
 * Decodes the route/swap mode of one chosen action into rewritten addresses and controls.
 * Assumes its caller registers the results; this module is purely combinational.
 */
`timescale 1ns/10ps
module arsa_rewrite
(
    // Frame and action
    input wire arsa_pkg::arsa_frame_t frame_i,
    input wire arsa_pkg::arsa_action_t act,
    input wire logic [arsa_pkg::IP_W-1:0] tab_sip,
    // Configuration
    input wire logic [arsa_pkg::HOP_W-1:0] hop_val,
    input wire logic [arsa_pkg::OFS_W-1:0] repl_bits,
    // Results
    output arsa_pkg::arsa_frame_t frame_o,
    output arsa_pkg::arsa_ctl_t ctl_o
);
    // A sequence-only action leaves frames of other classes untouched.
    wire seq_skip = act.seq && act.mode != arsa_pkg::MODE_DMAC_REPL && !frame_i.sam_seq;
    wire [arsa_pkg::MODE_W-1:0] mode = seq_skip ? '0 : act.mode;
    wire swp = mode[arsa_pkg::RS_SWAP];
    wire route = !swp;
    wire ovl = route && mode[arsa_pkg::RS_OVL];
    wire [2:0] sub = mode[2:0];
    wire [arsa_pkg::MAC_W-1:0] amac = act.mac;
    // The new SMAC or SIP after a swap is the old DMAC or DIP, so one test covers both.
    wire dmac_mc = frame_i.dmac[arsa_pkg::MAC_MC_BIT];
    wire dip_mc = frame_i.ipv6 ? frame_i.dip[127:120] == arsa_pkg::IP6_MC
                                : frame_i.dip[31:28] == arsa_pkg::IP4_MC;
    wire two_swap = sub == arsa_pkg::SUB_MSWAP || sub == arsa_pkg::SUB_BSWAP;
    wire uc_swap = sub == arsa_pkg::SUB_MSWAP_UC || sub == arsa_pkg::SUB_BSWAP_UC;
    wire mac_swap = swp && (two_swap || (uc_swap && !dmac_mc));
    wire dmac_repl = swp && sub == arsa_pkg::SUB_DMAC;
    wire smac_repl = swp && (sub == arsa_pkg::SUB_SMAC || sub == arsa_pkg::SUB_SMAC_ISWAP
                             || ((two_swap || uc_swap) && dmac_mc));
    wire ip_swap = swp && (sub == arsa_pkg::SUB_BSWAP || sub == arsa_pkg::SUB_ISWAP
                           || sub == arsa_pkg::SUB_SMAC_ISWAP
                           || (sub == arsa_pkg::SUB_BSWAP_UC && !dip_mc));
    wire sip_repl = swp && sub[2] && dip_mc;
    // Partial replacement takes the selected count of top DMAC bits from the action MAC and keeps the rest.
    wire part = act.mode == arsa_pkg::MODE_DMAC_REPL && act.seq;
    wire [arsa_pkg::MAC_W-1:0] pmask = ~({arsa_pkg::MAC_W{1'b1}} >> repl_bits);
    wire [arsa_pkg::MAC_W-1:0] dmac_new = part ? ((frame_i.dmac & ~pmask) | (amac & pmask))
                                               : amac;

    assign frame_o.dmac = dmac_repl ? dmac_new : mac_swap ? frame_i.smac : frame_i.dmac;
    assign frame_o.smac = smac_repl ? amac : mac_swap ? frame_i.dmac : frame_i.smac;
    assign frame_o.sip = sip_repl ? tab_sip : ip_swap ? frame_i.dip : frame_i.sip;
    assign frame_o.dip = ip_swap ? frame_i.sip : frame_i.dip;
    assign frame_o.ipv6 = frame_i.ipv6;
    assign frame_o.sam_seq = frame_i.sam_seq;
    assign frame_o.pol = frame_i.pol;

    assign ctl_o.uc_route = route && mode[arsa_pkg::RS_UC];
    assign ctl_o.mc_route = route && mode[arsa_pkg::RS_MC];
    assign ctl_o.pt_en = ovl && amac[arsa_pkg::AM_PT_EN];
    assign ctl_o.pt_idx = ovl ? amac[arsa_pkg::AM_PT_LSB +: arsa_pkg::PT_W] : '0;
    assign ctl_o.pol_en = ovl && amac[arsa_pkg::AM_POL_EN];
    assign ctl_o.pol_idx = ctl_o.pol_en ? amac[arsa_pkg::AM_POL_LSB +: arsa_pkg::POL_W] : '0;
    assign ctl_o.dom = act.dom;
    assign ctl_o.hop_preset = act.hop && swp && sub[2];
    assign ctl_o.hop_dec = act.hop && !ctl_o.hop_preset;
    assign ctl_o.hop_val = hop_val;
endmodule

// ### rtl/arsa_top.sv
/*
 * Access-list action stage: two keyed lookups, hit statistics, action choice and rewrite.
 * Assumes an external matcher that answers a lookup request in the same cycle and
 * an AHB-Lite master issuing single word transfers.
 */
// Implementation choices: the register addresses and the AHB-Lite register port.
// Contract
// - Choose each lookup's key from configured selection.
// - Build keys and run two lookups.
// - Count hits per lookup.
// - Matched action, else configured default action.
// - Four-bit mode; zero changes nothing.
// - Routing bit 0 enables unicast routing.
// - Routing bit 1 enables multicast routing.
// - Routing bit 2 overloads the action MAC.
// - Swap mode decodes low three bits.
// - Sub-modes 0,1 replace DMAC, SMAC from MAC.
// - Sub-mode 2 swaps; multicast SMAC replaced.
// - Sub-mode 3 swaps only unicast DMAC.
// - Sub-mode 4 swaps MACs and IPs.
// - Sub-mode 5 swaps each pair when unicast.
// - Sub-mode 6 swaps IPs only.
// - Sub-mode 7 replaces SMAC, swaps IPs.
// - New SIP comes from policer-indexed table.
// - Action MAC is the written address.
// - Overloaded bits give pass-through override, index.
// - Bit 16 enables bits 26:17 policer.
// - Domain select picks timing configuration.
// - Swap sub-modes 4-7 preset hop count.
// - Mode 8 with sequence bit: partial DMAC.
`timescale 1ns/10ps
module arsa_top #(
    parameter int SIP_DEPTH = arsa_pkg::SIP_DEPTH_DEF,
    parameter int CNT_W = 32
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Frame from the classifier
    input wire logic in_valid,
    input wire arsa_pkg::arsa_frame_t in_frame,
    output logic in_ready,
    // Matcher lookup
    output logic lk_req,
    output logic lk_num,
    output logic [arsa_pkg::KEY_W-1:0] lk_key,
    input wire logic lk_hit,
    input wire arsa_pkg::arsa_action_t lk_action,
    // Result to forwarding and rewriter
    output logic out_valid,
    output arsa_pkg::arsa_frame_t out_frame,
    output arsa_pkg::arsa_ctl_t out_ctl,
    input wire logic out_ready
);
    localparam int IDX_W = (SIP_DEPTH > 1) ? $clog2(SIP_DEPTH) : 1;

    arsa_pkg::arsa_state_t state;
    arsa_pkg::arsa_frame_t fr;
    arsa_pkg::arsa_action_t act0;
    arsa_pkg::arsa_action_t act1;
    logic hit0;
    logic hit1;
    logic [31:0] ctrl;
    logic [31:0] def_act;
    logic [31:0] def_mlo;
    logic [15:0] def_mhi;
    logic [31:0] swap_ctrl;
    logic [CNT_W-1:0] cnt0;
    logic [CNT_W-1:0] cnt1;
    logic [3:0][31:0] sip_tab [SIP_DEPTH];
    logic dp_wr;
    logic [11:0] dp_addr;
    logic [31:0] rd_data;

    // Keys: selection 0 gives the MAC pair, 1 the low 48 bits of the IP pair.
    function automatic logic [arsa_pkg::KEY_W-1:0] mk_key(arsa_pkg::arsa_frame_t f, logic sel);
        mk_key = sel ? {f.dip[47:0], f.sip[47:0]} : {f.dmac, f.smac};
    endfunction

    // Bus address phase and write decode.
    wire ap_valid = hsel && htrans[1] && hready;
    wire wr_ctrl = dp_wr && dp_addr == arsa_pkg::CTRL_OFS;
    wire wr_dact = dp_wr && dp_addr == arsa_pkg::DEFACT_OFS;
    wire wr_dmlo = dp_wr && dp_addr == arsa_pkg::DEFMLO_OFS;
    wire wr_dmhi = dp_wr && dp_addr == arsa_pkg::DEFMHI_OFS;
    wire wr_swpc = dp_wr && dp_addr == arsa_pkg::SWAPC_OFS;
    wire clr0 = dp_wr && dp_addr == arsa_pkg::HIT0_OFS;
    wire clr1 = dp_wr && dp_addr == arsa_pkg::HIT1_OFS;
    wire [11:0] rd_addr = haddr[11:0];
    wire [11:0] rd_rel = rd_addr - arsa_pkg::SIP_OFS;
    wire rd_in_tab = rd_addr >= arsa_pkg::SIP_OFS && rd_rel[11:4] < 8'(SIP_DEPTH);

    wire arsa_pkg::arsa_action_t dflt = '{
        mode: def_act[arsa_pkg::DA_MODE_LSB +: arsa_pkg::MODE_W],
        mac: {def_mhi, def_mlo},
        dom: def_act[arsa_pkg::DA_DOM_LSB +: arsa_pkg::DOM_W],
        hop: def_act[arsa_pkg::DA_HOP],
        seq: def_act[arsa_pkg::DA_SEQ]
    };
    wire en0 = ctrl[arsa_pkg::CTRL_EN0];
    wire en1 = ctrl[arsa_pkg::CTRL_EN1];
    // Lookup 1 takes precedence when both hit.
    wire arsa_pkg::arsa_action_t sel_act = hit1 ? act1 : hit0 ? act0 : dflt;
    wire [IDX_W-1:0] sip_idx = fr.pol[IDX_W-1:0];
    wire [arsa_pkg::IP_W-1:0] tab_sip = sip_tab[sip_idx];
    wire load = state == arsa_pkg::ST_OUT && !out_valid;
    wire take = state == arsa_pkg::ST_IDLE && in_valid && in_ready;
    wire hit_now = lk_req && lk_hit;

    arsa_pkg::arsa_frame_t rw_frame;
    arsa_pkg::arsa_ctl_t rw_ctl;

    arsa_rewrite arsa_rewrite_i (
        .frame_i(fr),
        .act(sel_act),
        .tab_sip(tab_sip),
        .hop_val(swap_ctrl[arsa_pkg::SC_HOP_LSB +: arsa_pkg::HOP_W]),
        .repl_bits(swap_ctrl[arsa_pkg::SC_OFS_LSB +: arsa_pkg::OFS_W]),
        .frame_o(rw_frame),
        .ctl_o(rw_ctl)
    );

    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (rd_addr == arsa_pkg::CTRL_OFS)
            rd_data = ctrl;
        else if (rd_addr == arsa_pkg::DEFACT_OFS)
            rd_data = def_act;
        else if (rd_addr == arsa_pkg::DEFMLO_OFS)
            rd_data = def_mlo;
        else if (rd_addr == arsa_pkg::DEFMHI_OFS)
            rd_data = {16'h0000, def_mhi};
        else if (rd_addr == arsa_pkg::SWAPC_OFS)
            rd_data = swap_ctrl;
        else if (rd_addr == arsa_pkg::HIT0_OFS)
            rd_data = 32'(cnt0);
        else if (rd_addr == arsa_pkg::HIT1_OFS)
            rd_data = 32'(cnt1);
        else if (rd_addr == arsa_pkg::STAT_OFS)
            rd_data = {28'h0000000, hit1, hit0, state};
        else if (rd_in_tab)
            rd_data = sip_tab[rd_rel[IDX_W+3:4]][rd_rel[3:2]];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr <= 1'b0;
            dp_addr <= 12'h000;
            hrdata <= 32'h0000_0000;
        end
        else if (hready)
        begin
            dp_wr <= ap_valid && hwrite;
            dp_addr <= haddr[11:0];
            if (ap_valid && !hwrite)
                hrdata <= rd_data;
        end
    end

    // The slave never stretches a transfer and never signals an error.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl <= arsa_pkg::CTRL_RST;
            def_act <= arsa_pkg::DEFACT_RST;
            def_mlo <= arsa_pkg::DEFMAC_RST;
            def_mhi <= arsa_pkg::DEFMAC_RST[15:0];
            swap_ctrl <= arsa_pkg::SWAPC_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= hwdata;
            if (wr_dact)
                def_act <= hwdata;
            if (wr_dmlo)
                def_mlo <= hwdata;
            if (wr_dmhi)
                def_mhi <= hwdata[15:0];
            if (wr_swpc)
                swap_ctrl <= hwdata;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < SIP_DEPTH * 4; gi++)
        begin : g_sip
            wire wr_w = dp_wr && dp_addr == arsa_pkg::SIP_OFS + 12'(gi * 4);
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    sip_tab[gi / 4][gi % 4] <= 32'h0000_0000;
                else if (wr_w)
                    sip_tab[gi / 4][gi % 4] <= hwdata;
            end
        end
    endgenerate

    // A hit in the same cycle as a software clear still counts.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt0 <= '0;
            cnt1 <= '0;
        end
        else
        begin
            if (state == arsa_pkg::ST_LK0 && hit_now)
                cnt0 <= (clr0 ? '0 : cnt0) + 1'b1;
            else if (clr0)
                cnt0 <= '0;
            if (state == arsa_pkg::ST_LK1 && hit_now)
                cnt1 <= (clr1 ? '0 : cnt1) + 1'b1;
            else if (clr1)
                cnt1 <= '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= arsa_pkg::ST_IDLE;
            in_ready <= 1'b0;
            lk_req <= 1'b0;
            lk_num <= 1'b0;
            lk_key <= '0;
            fr <= '0;
            hit0 <= 1'b0;
            hit1 <= 1'b0;
            act0 <= '0;
            act1 <= '0;
            out_valid <= 1'b0;
            out_frame <= '0;
            out_ctl <= '0;
        end
        else
        begin
            case (state)
                arsa_pkg::ST_IDLE:
                begin
                    in_ready <= 1'b1;
                    if (take)
                    begin
                        in_ready <= 1'b0;
                        fr <= in_frame;
                        lk_req <= en0;
                        lk_num <= 1'b0;
                        lk_key <= mk_key(in_frame, ctrl[arsa_pkg::CTRL_SEL0]);
                        state <= arsa_pkg::ST_LK0;
                    end
                end
                arsa_pkg::ST_LK0:
                begin
                    hit0 <= hit_now;
                    act0 <= hit_now ? lk_action : dflt;
                    lk_req <= en1;
                    lk_num <= 1'b1;
                    lk_key <= mk_key(fr, ctrl[arsa_pkg::CTRL_SEL1]);
                    state <= arsa_pkg::ST_LK1;
                end
                arsa_pkg::ST_LK1:
                begin
                    hit1 <= hit_now;
                    act1 <= hit_now ? lk_action : dflt;
                    lk_req <= 1'b0;
                    state <= arsa_pkg::ST_OUT;
                end
                arsa_pkg::ST_OUT:
                begin
                    if (load)
                    begin
                        out_valid <= 1'b1;
                        out_frame <= rw_frame;
                        out_ctl <= rw_ctl;
                    end
                    else if (out_ready)
                    begin
                        out_valid <= 1'b0;
                        in_ready <= 1'b1;
                        state <= arsa_pkg::ST_IDLE;
                    end
                end
                default:
                    state <= arsa_pkg::ST_IDLE;
            endcase
        end
    end

    // Checks on the sequencing and the decoded results.
    lookup_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take |=> state == arsa_pkg::ST_LK0 && lk_req == $past(en0) ##1
                 state == arsa_pkg::ST_LK1 && lk_num ##1 state == arsa_pkg::ST_OUT)
        else $error("lookup sequence broken");

    key_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == arsa_pkg::ST_LK1 && !$past(wr_ctrl))
        |-> lk_key == mk_key(fr, ctrl[arsa_pkg::CTRL_SEL1]))
        else $error("second key uses wrong selection");

    hit_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == arsa_pkg::ST_LK0 && hit_now && !clr0) |=> cnt0 == $past(cnt0) + 1'b1)
        else $error("hit counter did not advance");

    default_act_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (load && !hit0 && !hit1 && !wr_dact)
        |=> out_valid && out_ctl.dom == def_act[arsa_pkg::DA_DOM_LSB +: arsa_pkg::DOM_W])
        else $error("default action not applied");

    mode_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (load && sel_act.mode == 4'h0)
        |=> out_frame == fr && !out_ctl.uc_route && !out_ctl.mc_route)
        else $error("mode zero altered the frame");

    route_uc_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (load && !sel_act.seq && sel_act.mode == 4'h3)
        |=> out_ctl.uc_route && out_ctl.mc_route && out_frame.dmac == fr.dmac)
        else $error("routing updates not enabled");

    overload_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (load && !sel_act.seq && sel_act.mode == 4'h4 && sel_act.mac[16])
        |=> out_ctl.pol_en && out_ctl.pol_idx == sel_act.mac[26:17]
            && out_ctl.pt_idx == sel_act.mac[6:1])
        else $error("overloaded fields misdecoded");

    dmac_repl_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (load && !sel_act.seq && sel_act.mode == 4'h8)
        |=> out_frame.dmac == sel_act.mac && out_frame.smac == fr.smac)
        else $error("DMAC not replaced");

    mac_swap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (load && !sel_act.seq && sel_act.mode == 4'ha && !fr.dmac[40])
        |=> out_frame.dmac == fr.smac && out_frame.smac == fr.dmac)
        else $error("MAC swap wrong");

    sip_table_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (load && !sel_act.seq && sel_act.mode == 4'hf && !fr.ipv6 && fr.dip[31:28] == 4'he)
        |=> out_frame.sip == tab_sip && out_frame.smac == sel_act.mac)
        else $error("SIP not taken from table");

    hop_preset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (load && sel_act.hop && sel_act.mode[3:2] == 2'b11)
        |=> out_ctl.hop_preset && !out_ctl.hop_dec)
        else $error("hop count not preset");
endmodule

// ### test/acl_route_swap_actions_bench.sv
/* Self-checking bench for the access-list action stage.
   Assumes the matcher model answers at once and out_ready stays high. */
`timescale 1ns/10ps
module acl_route_swap_actions_bench;
    localparam logic [47:0] D = 48'h0000_1111_2222;
    localparam logic [47:0] S = 48'h0000_3333_4444;
    localparam logic [47:0] M = 48'h0000_5555_6666;
    localparam logic [127:0] DI = 128'h0a00_0001;
    localparam logic [127:0] SI = 128'h0a00_0002;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic in_valid = 1'b0;
    logic [1:0] hit_en = 2'h0;
    logic hreadyout, hresp, in_ready, lk_req, lk_num, lk_hit, out_valid;
    logic [31:0] hrdata;
    logic [arsa_pkg::KEY_W-1:0] lk_key;
    arsa_pkg::arsa_frame_t in_frame = '0;
    arsa_pkg::arsa_frame_t fr = '{D, S, DI, SI, 1'b0, 1'b0, 10'h0};
    arsa_pkg::arsa_frame_t out_frame;
    arsa_pkg::arsa_action_t act = '0;
    arsa_pkg::arsa_action_t lk_action;
    arsa_pkg::arsa_ctl_t out_ctl;
    int miscompares = 0;
    int compares = 0;
    arsa_top arsa_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .in_valid(in_valid), .in_frame(in_frame), .in_ready(in_ready), .lk_req(lk_req),
        .lk_num(lk_num), .lk_key(lk_key), .lk_hit(lk_hit), .lk_action(lk_action),
        .out_valid(out_valid), .out_frame(out_frame), .out_ctl(out_ctl), .out_ready(1'b1));
    arsa_match_model arsa_match_model_i (.lk_req(lk_req), .lk_num(lk_num),
        .hit_en(hit_en), .act(act), .lk_hit(lk_hit), .lk_action(lk_action));
    initial
    begin
        forever #25 hclk = ~hclk;
    end
    task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // A frame is offered, the matcher primed, and the result awaited.
    task automatic run(input logic [1:0] h, input arsa_pkg::arsa_action_t a);
        int n = 0;
        hit_en <= h;
        act <= a;
        in_frame <= fr;
        in_valid <= 1'b1;
        do @(posedge hclk); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
        do
        begin
            @(posedge hclk);
            n++;
            if (n == 1)
                chk("key0", lk_key, {fr.dmac, fr.smac});
            if (n == 2)
                chk("key1", lk_key, {fr.dip[47:0], fr.sip[47:0]});
        end
        while (out_valid !== 1'b1 && n < 20);
        chk("out_valid", out_valid, 1'b1);
    endtask
    task automatic t_regs();
        logic [31:0] r;
        bus(1'b0, 32'h10, 32'h0, r);
        chk("swap_ctrl", r, 32'h40);
        bus(1'b1, 32'h0, 32'hb, r);
        bus(1'b0, 32'h0, 32'h0, r);
        chk("ctrl", r, 32'hb);
        bus(1'b0, 32'h30, 32'h0, r);
        chk("unmapped", r, 32'h0);
    endtask
    task automatic t_mac();
        run(2'h1, '{4'h8, M, 2'h2, 1'b0, 1'b0});
        chk("dmac", out_frame.dmac, M);
        chk("smac", out_frame.smac, S);
        chk("dom", out_ctl.dom, 2'h2);
        run(2'h1, '{4'h9, M, 2'h0, 1'b0, 1'b0});
        chk("smac", out_frame.smac, M);
        chk("dmac", out_frame.dmac, D);
    endtask
    // Lookup 1 hits here, so its counter and action path are exercised.
    task automatic t_swap();
        logic [31:0] r;
        run(2'h2, '{4'ha, M, 2'h0, 1'b0, 1'b0});
        chk("dmac", out_frame.dmac, S);
        chk("smac", out_frame.smac, D);
        run(2'h2, '{4'he, M, 2'h0, 1'b0, 1'b0});
        chk("dip", out_frame.dip, SI);
        chk("sip", out_frame.sip, DI);
        chk("dmac", out_frame.dmac, D);
        bus(1'b1, 32'h40, 32'hc0a8_0001, r);
        fr.dip = 128'he000_0001;
        run(2'h2, '{4'hf, M, 2'h0, 1'b1, 1'b0});
        chk("smac", out_frame.smac, M);
        chk("sip", out_frame.sip, 128'hc0a8_0001);
        chk("dip", out_frame.dip, SI);
        chk("hop", out_ctl.hop_preset, 1'b1);
        chk("hop_val", out_ctl.hop_val, 8'h40);
        fr.dip = DI;
    endtask
    task automatic t_route();
        run(2'h1, '{4'h3, M, 2'h0, 1'b0, 1'b0});
        chk("uc", out_ctl.uc_route, 1'b1);
        chk("mc", out_ctl.mc_route, 1'b1);
        chk("dmac", out_frame.dmac, D);
        run(2'h1, '{4'h4, 48'h0007_000b, 2'h0, 1'b0, 1'b0});
        chk("pt_en", out_ctl.pt_en, 1'b1);
        chk("pt_idx", out_ctl.pt_idx, 6'h5);
        chk("pol_en", out_ctl.pol_en, 1'b1);
        chk("pol_idx", out_ctl.pol_idx, 10'h3);
        chk("dmac", out_frame.dmac, D);
    endtask
    task automatic t_dflt();
        logic [31:0] r;
        run(2'h0, '{4'h8, M, 2'h0, 1'b0, 1'b0});
        chk("dmac", out_frame.dmac, D);
        chk("uc", out_ctl.uc_route, 1'b0);
        bus(1'b1, 32'h4, 32'h29, r);
        bus(1'b1, 32'h8, 32'h5555_6666, r);
        run(2'h0, '{4'h8, D, 2'h0, 1'b0, 1'b0});
        chk("smac", out_frame.smac, M);
        chk("dom", out_ctl.dom, 2'h2);
        bus(1'b0, 32'h14, 32'h0, r);
        chk("hits0", r, 32'h4);
        bus(1'b0, 32'h18, 32'h0, r);
        chk("hits1", r, 32'h3);
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #100000;
        miscompares++;
        print_verdict();
    end
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_mac();
        t_swap();
        t_route();
        t_dflt();
        print_verdict();
    end
endmodule

// ### test/arsa_match_model.sv
/* Behavioural second-stage matcher answering each lookup in the same cycle.
   Assumes the bench programs which lookups hit and the action returned. */
`timescale 1ns/10ps
module arsa_match_model
(
    // Lookup request
    input wire logic lk_req,
    input wire logic lk_num,
    // Programmed answer
    input wire logic [1:0] hit_en,
    input wire arsa_pkg::arsa_action_t act,
    // Answer
    output logic lk_hit,
    output arsa_pkg::arsa_action_t lk_action
);
    // Outside a request the answer is inverted so stale values are never trusted.
    assign lk_hit = lk_req ? hit_en[lk_num] : ~hit_en[lk_num];
    assign lk_action = lk_req ? act : ~act;
endmodule
